//--- hdl/fes_pkg.sv
// Purpose: Shared constants for the framer error status block
// Assumes: Two channels, 8-bit status registers
// Notes:   Bit positions are common to both channels
package fes_pkg;
  localparam logic [7:0] FES_ADDR_STATUS_A = 8'h08;
  localparam logic [7:0] FES_ADDR_STATUS_B = 8'h09;
  localparam logic [7:0] FES_STATUS_RESET  = 8'h00;
  localparam int         FES_BIT_TX_FAIL   = 7;
  localparam int         FES_BIT_TX_CYCLE  = 6;
  localparam int         FES_BIT_TX_CSUM   = 5;
  localparam int         FES_BIT_TX_LEN    = 4;
  localparam int         FES_BIT_RX_CSUM   = 3;
  localparam int         FES_BIT_RX_LEN    = 2;
  localparam int         FES_BIT_RX_FRAME  = 1;
  localparam int         FES_BIT_RX_PARITY = 0;
  localparam int         FES_CSUM_W        = 6;
  localparam int         FES_CNT_W         = 8;
  localparam int         FES_NCH           = 2;
endpackage

//--- hdl/fes_top.sv
// Purpose: Per-channel error detection and clear-on-read status for two framers
// Assumes: Framer datapath supplies event strobes, counts and checksums
// Notes:   Register port is a simple read/address strobe from the host serial port
`timescale 1ns/1ps
module fes_top
  import fes_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                            i_clk,
  input  wire logic                            i_sys_rst,
  input  wire logic                            i_ce,
  // Register read port
  input  wire logic                            i_rd,
  input  wire logic [7:0]                      i_addr,
  output logic      [7:0]                      o_rdata,
  // Per-channel configuration
  input  wire logic [FES_NCH-1:0]              i_cycle_timer_enable,
  input  wire logic [FES_NCH-1:0]              i_host_checksum_verify,
  input  wire logic [FES_NCH-1:0]              i_delete_on_error,
  input  wire logic [FES_NCH-1:0]              i_send_message_cmd,
  input  wire logic [FES_NCH-1:0]              i_trigger_cmd,
  // Transmit side events and data
  input  wire logic [FES_NCH-1:0]              i_tx_start,
  input  wire logic [FES_NCH-1:0]              i_queue_empty,
  input  wire logic [FES_NCH-1:0]              i_msg_preloaded,
  input  wire logic [FES_NCH-1:0]              i_tx_check,
  input  wire logic [FES_NCH*FES_CSUM_W-1:0]   i_tx_csum_calc,
  input  wire logic [FES_NCH*FES_CSUM_W-1:0]   i_tx_csum_host,
  input  wire logic [FES_NCH*FES_CNT_W-1:0]    i_tx_octets,
  input  wire logic [FES_NCH*FES_CNT_W-1:0]    i_tx_octet_count,
  input  wire logic [FES_NCH-1:0]              i_tx_fail,
  // Receive side events and data
  input  wire logic [FES_NCH-1:0]              i_rx_done,
  input  wire logic [FES_NCH*FES_CSUM_W-1:0]   i_rx_csum_calc,
  input  wire logic [FES_NCH*FES_CSUM_W-1:0]   i_rx_csum_recv,
  input  wire logic [FES_NCH*FES_CNT_W-1:0]    i_rx_octets,
  input  wire logic [FES_NCH*FES_CNT_W-1:0]    i_rx_expected_count,
  input  wire logic [FES_NCH-1:0]              i_rx_frame_err,
  input  wire logic [FES_NCH-1:0]              i_rx_parity_err,
  // Outputs to framer and interrupt logic
  output logic      [FES_NCH-1:0]              o_tx_suppress,
  output logic      [FES_NCH-1:0]              o_timer_start,
  output logic      [FES_NCH-1:0]              o_transmit_queue_reset,
  output logic      [FES_NCH-1:0]              o_rx_fault_irq
);

  typedef enum logic [1:0]
  {
    FES_TMR_IDLE = 2'b01,
    FES_TMR_RUN  = 2'b10
  } fes_tmr_t;

  logic [7:0]          status_r [FES_NCH];
  logic [7:0]          status_nxt [FES_NCH];
  logic [FES_NCH-1:0]  rd_hit;
  fes_tmr_t            tmr_r [FES_NCH];
  logic [7:0]          rdata_nxt;

  function automatic logic [FES_NCH-1:0] fes_decode(input logic rd, input logic [7:0] addr);
    logic [FES_NCH-1:0] hit;
    hit    = '0;
    hit[0] = rd && (addr == FES_ADDR_STATUS_A);
    hit[1] = rd && (addr == FES_ADDR_STATUS_B);
    return hit;
  endfunction

  assign rd_hit = fes_decode(i_rd, i_addr);

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (rd_hit[0])
    begin
      rdata_nxt = status_r[0];
    end
    else if (rd_hit[1])
    begin
      rdata_nxt = status_r[1];
    end
  end

  // Read data is registered, captured together with the clear
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_ce)
    begin
      o_rdata <= rdata_nxt;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < FES_NCH; ch++)
    begin : g_ch
      logic [FES_CSUM_W-1:0] tx_cc;
      logic [FES_CSUM_W-1:0] tx_ch;
      logic [FES_CSUM_W-1:0] rx_cc;
      logic [FES_CSUM_W-1:0] rx_cr;
      logic [FES_CNT_W-1:0]  tx_n;
      logic [FES_CNT_W-1:0]  tx_exp;
      logic [FES_CNT_W-1:0]  rx_n;
      logic [FES_CNT_W-1:0]  rx_exp;
      logic [7:0]            ev;
      logic                  tx_csum_bad;
      logic                  tx_len_bad;

      assign tx_cc  = i_tx_csum_calc[ch*FES_CSUM_W +: FES_CSUM_W];
      assign tx_ch  = i_tx_csum_host[ch*FES_CSUM_W +: FES_CSUM_W];
      assign rx_cc  = i_rx_csum_calc[ch*FES_CSUM_W +: FES_CSUM_W];
      assign rx_cr  = i_rx_csum_recv[ch*FES_CSUM_W +: FES_CSUM_W];
      assign tx_n   = i_tx_octets[ch*FES_CNT_W +: FES_CNT_W];
      assign tx_exp = i_tx_octet_count[ch*FES_CNT_W +: FES_CNT_W];
      assign rx_n   = i_rx_octets[ch*FES_CNT_W +: FES_CNT_W];
      assign rx_exp = i_rx_expected_count[ch*FES_CNT_W +: FES_CNT_W];

      assign tx_csum_bad = i_tx_check[ch] && i_host_checksum_verify[ch] && (tx_cc != tx_ch);
      assign tx_len_bad  = i_tx_check[ch] && (tx_n != tx_exp);

      always_comb
      begin
        ev                    = 8'h00;
        ev[FES_BIT_TX_FAIL]   = i_tx_fail[ch];
        ev[FES_BIT_TX_CYCLE]  = i_tx_start[ch] && i_queue_empty[ch]
                                && i_cycle_timer_enable[ch];
        ev[FES_BIT_TX_CSUM]   = tx_csum_bad;
        ev[FES_BIT_TX_LEN]    = tx_len_bad;
        ev[FES_BIT_RX_CSUM]   = i_rx_done[ch] && (rx_cc != rx_cr);
        ev[FES_BIT_RX_LEN]    = i_rx_done[ch] && (rx_n != rx_exp);
        ev[FES_BIT_RX_FRAME]  = i_rx_frame_err[ch];
        ev[FES_BIT_RX_PARITY] = i_rx_parity_err[ch];
        // Set beats clear so an event during a read is seen next read
        status_nxt[ch] = (rd_hit[ch] ? 8'h00 : status_r[ch]) | ev;
      end

      always_ff @(posedge i_clk or posedge i_sys_rst)
      begin
        if (i_sys_rst)
        begin
          status_r[ch] <= FES_STATUS_RESET;
        end
        else if (i_ce)
        begin
          status_r[ch] <= status_nxt[ch];
        end
      end

      // Timer state: armed by enable, run on send or trigger
      always_ff @(posedge i_clk or posedge i_sys_rst)
      begin
        if (i_sys_rst)
        begin
          tmr_r[ch] <= FES_TMR_IDLE;
        end
        else if (i_ce)
        begin
          case (tmr_r[ch])
            FES_TMR_IDLE:
            begin
              if (i_cycle_timer_enable[ch] && (i_send_message_cmd[ch] || i_trigger_cmd[ch]))
              begin
                tmr_r[ch] <= FES_TMR_RUN;
              end
            end
            FES_TMR_RUN:
            begin
              if (!i_cycle_timer_enable[ch])
              begin
                tmr_r[ch] <= FES_TMR_IDLE;
              end
            end
            default:
            begin
              tmr_r[ch] <= FES_TMR_IDLE;
            end
          endcase
        end
      end

      always_comb
      begin
        o_timer_start[ch] = (tmr_r[ch] == FES_TMR_IDLE) && i_cycle_timer_enable[ch]
                            && (i_send_message_cmd[ch] || i_trigger_cmd[ch]);
        // Live and latched checksum error both block, but only while the cycle timer is enabled
        o_tx_suppress[ch] = i_cycle_timer_enable[ch]
                            && (tx_csum_bad || status_r[ch][FES_BIT_TX_CSUM]);
        // Partial loads cannot be deleted safely, so preload is required
        o_transmit_queue_reset[ch] = i_delete_on_error[ch] && i_msg_preloaded[ch]
                                     && (tx_csum_bad || tx_len_bad);
        o_rx_fault_irq[ch] = i_ce && (i_rx_frame_err[ch] || i_rx_parity_err[ch]);
      end
    end
  endgenerate

endmodule

//--- verification/fes_checker.sv
// Purpose: Port assertions for error status
// Assumes: One clock, async high reset
// Notes:   Bound into fes_top
`timescale 1ns/1ps
module fes_checker
  import fes_pkg::*;
(
  input wire logic       i_clk, i_sys_rst, i_ce, i_rd,
  input wire logic [7:0] i_addr, o_rdata,
  input wire logic [1:0] i_tx_fail, i_tx_start, i_queue_empty, i_cycle_timer_enable,
  input wire logic [1:0] i_rx_frame_err, i_rx_parity_err, o_rx_fault_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire rda = i_ce && i_rd && i_addr == FES_ADDR_STATUS_A;
  wire rdb = i_ce && i_rd && i_addr == FES_ADDR_STATUS_B;
  property p_b7; i_ce && i_tx_fail[1] ##1 rdb |=> o_rdata[7]; endproperty
  a_b7: assert property (p_b7) else $error("b7");
  property p_b6; i_ce && i_tx_start[0] && i_queue_empty[0] && i_cycle_timer_enable[0] ##1 rda |=> o_rdata[6]; endproperty
  a_b6: assert property (p_b6) else $error("b6");
  property p_b1; i_ce && i_rx_frame_err[1] ##1 rdb |=> o_rdata[1]; endproperty
  a_b1: assert property (p_b1) else $error("b1");
  property p_b0; i_ce && i_rx_parity_err[0] ##1 rda |=> o_rdata[0]; endproperty
  a_b0: assert property (p_b0) else $error("b0");
  // Set must win over the clearing read
  property p_keep; rda && i_rx_parity_err[0] ##1 rda |=> o_rdata[0]; endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_unmap; i_ce && i_rd && i_addr[7:1] != 7'h04 |=> o_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmap");
  property p_irq; i_ce && (i_rx_frame_err[0] || i_rx_parity_err[0]) |-> o_rx_fault_irq[0]; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_isrc; o_rx_fault_irq[1] |-> i_ce && (i_rx_frame_err[1] || i_rx_parity_err[1]); endproperty
  a_isrc: assert property (p_isrc) else $error("isrc");
  c_keep: cover property (rda && i_rx_parity_err[0] ##1 rda);
  c_cyc: cover property (i_tx_start[0] && i_queue_empty[0] && i_cycle_timer_enable[0]);
  c_unmap: cover property (i_rd && i_addr == 8'h0B);
endmodule
bind fes_top fes_checker chk (.*);

//--- verification/fes_field_dev.sv
// Purpose: Field device stand-in making receive events
// Assumes: Changes at time zero and on falling edges
// Notes:   Frame and parity errors sparse so clean messages occur too
`timescale 1ns/1ps
module fes_field_dev
(
  input  wire logic   i_clk,
  output logic [1:0]  o_done, o_fe, o_pe,
  output logic [11:0] o_cc, o_cr,
  output logic [15:0] o_oc, o_ex
);
  int seed = 47830;
  initial forever
  begin
    o_done = 2'($random(seed));
    {o_fe, o_pe} = 4'($random(seed) & $random(seed) & $random(seed));
    o_cc = 12'($random(seed));
    o_cr = o_cc ^ (12'($random(seed)) & 12'h041);
    o_oc = 16'($random(seed));
    o_ex = o_oc ^ (16'($random(seed)) & 16'h0101);
    @(negedge i_clk);
  end
endmodule

//--- verification/test_framer_error_status.sv
// Purpose: Random bench with a reference model
// Assumes: Inputs change at falling edges
// Notes:   Read data and interrupt checked every cycle
`timescale 1ns/1ps
module test_framer_error_status;
  import fes_pkg::*;
  logic i_clk = 0, i_sys_rst, i_ce, i_rd;
  logic [7:0] i_addr, o_rdata, exp_r = 8'h00, s;
  logic [7:0] st [2];
  logic [1:0] i_cycle_timer_enable, i_host_checksum_verify, i_delete_on_error, i_send_message_cmd;
  logic [1:0] i_trigger_cmd, i_tx_start, i_queue_empty, i_msg_preloaded, i_tx_check, i_tx_fail;
  logic [1:0] i_rx_done, i_rx_frame_err, i_rx_parity_err, o_rx_fault_irq;
  logic [11:0] i_tx_csum_calc, i_tx_csum_host, i_rx_csum_calc, i_rx_csum_recv;
  logic [15:0] i_tx_octets, i_tx_octet_count, i_rx_octets, i_rx_expected_count;
  logic [1:0] o_tx_suppress, o_timer_start, o_transmit_queue_reset, sup_e, tst_e, qrs_e, run_m = 2'b00;
  logic csb, lnb;
  int failures = 0, checks = 0, seed = 47823;
  always #5 i_clk = ~i_clk;
  fes_field_dev dev (.i_clk, .o_done(i_rx_done), .o_fe(i_rx_frame_err), .o_pe(i_rx_parity_err),
    .o_cc(i_rx_csum_calc), .o_cr(i_rx_csum_recv), .o_oc(i_rx_octets), .o_ex(i_rx_expected_count));
  fes_top uut (.*);
  always @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      st = '{8'h00, 8'h00};
      exp_r = 8'h00;
      run_m = 2'b00;
    end
    else if (i_ce)
    begin
      exp_r = 8'h00;
      for (int c = 0; c < 2; c++)
      begin
        s = {i_tx_fail[c], i_tx_start[c] & i_queue_empty[c] & i_cycle_timer_enable[c],
          i_tx_check[c] & i_host_checksum_verify[c] & (i_tx_csum_calc[6*c+:6] != i_tx_csum_host[6*c+:6]),
          i_tx_check[c] & (i_tx_octets[8*c+:8] != i_tx_octet_count[8*c+:8]),
          i_rx_done[c] & (i_rx_csum_calc[6*c+:6] != i_rx_csum_recv[6*c+:6]),
          i_rx_done[c] & (i_rx_octets[8*c+:8] != i_rx_expected_count[8*c+:8]),
          i_rx_frame_err[c], i_rx_parity_err[c]};
        if (i_rd && i_addr == FES_ADDR_STATUS_A + c)
        begin
          exp_r = st[c];
          st[c] = 8'h00;
        end
        st[c] = st[c] | s;
        // Timer leaves idle on send or trigger while enabled, drops when disabled
        if (!run_m[c] && i_cycle_timer_enable[c] && (i_send_message_cmd[c] || i_trigger_cmd[c]))
          run_m[c] = 1'b1;
        else if (run_m[c] && !i_cycle_timer_enable[c])
          run_m[c] = 1'b0;
      end
    end
  task chk_status(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_line(input string nm, input logic [1:0] e, input logic [1:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #40000;
    failures++;
    print_verdict;
  end
  // Reset first 16 cycles, again once mid-run
  initial
  begin
    for (int n = 0; n < 3016; n++)
    begin
      i_sys_rst = n < 16 || n == 1500;
      i_ce = 3'($random(seed)) != 3'h0;
      i_rd = 1'($random(seed));
      i_addr = 8'h08 ^ (8'($random(seed)) & 8'h03);
      // Host sometimes breaks the preload duty, to provoke the empty-queue flag
      {i_cycle_timer_enable, i_host_checksum_verify, i_delete_on_error, i_queue_empty,
        i_msg_preloaded} = 10'($random(seed));
      {i_send_message_cmd, i_trigger_cmd, i_tx_start, i_tx_check, i_tx_fail} =
        10'($random(seed) & $random(seed));
      i_tx_csum_calc = 12'($random(seed));
      i_tx_csum_host = i_tx_csum_calc ^ (12'($random(seed)) & 12'h041);
      i_tx_octets = 16'($random(seed));
      // Length mismatches injected; host recovery left to the queue reset check
      i_tx_octet_count = i_tx_octets ^ (16'($random(seed)) & 16'h0101);
      #1;
      for (int c = 0; c < 2; c++)
      begin
        csb = i_tx_check[c] & i_host_checksum_verify[c] & (i_tx_csum_calc[6*c+:6] != i_tx_csum_host[6*c+:6]);
        lnb = i_tx_check[c] & (i_tx_octets[8*c+:8] != i_tx_octet_count[8*c+:8]);
        sup_e[c] = i_cycle_timer_enable[c] & (csb | st[c][5]);
        tst_e[c] = !run_m[c] & i_cycle_timer_enable[c] & (i_send_message_cmd[c] | i_trigger_cmd[c]);
        qrs_e[c] = i_delete_on_error[c] & i_msg_preloaded[c] & (csb | lnb);
      end
      chk_line("irq", {2{i_ce}} & (i_rx_frame_err | i_rx_parity_err), o_rx_fault_irq);
      chk_line("suppress", sup_e, o_tx_suppress);
      chk_line("timer_start", tst_e, o_timer_start);
      chk_line("queue_reset", qrs_e, o_transmit_queue_reset);
      @(negedge i_clk);
      chk_status("status", exp_r, o_rdata);
    end
    print_verdict;
  end
endmodule
